// File: rtl/status_irq_defines.vh
// Register offsets, reset values and bit positions of the status-flag block
`ifndef STATUS_IRQ_DEFINES_VH
`define STATUS_IRQ_DEFINES_VH

// ==========================================================================
// Register indices (byte address is four times the index)
`define GLOBAL_EVENT_FLAGS_IDX      3'h0
`define REGULATION_EVENT_FLAGS_IDX  3'h1
`define GLOBAL_EVENT_UNMASK_IDX     3'h2
`define REGULATION_EVENT_UNMASK_IDX 3'h3
`define LIVE_CONDITION_VIEW_IDX     3'h4
`define CONDITION_CONTROL_IDX       3'h5

// ==========================================================================
// Reset values
`define GLOBAL_FLAGS_RESET          8'h00
`define REGULATION_FLAGS_RESET      8'h00
`define GLOBAL_UNMASK_RESET         8'h01
`define REGULATION_UNMASK_RESET     8'h00
`define CONDITION_CONTROL_RESET     8'h00

// ==========================================================================
// Global flag bit positions
`define BIT_SUPPLY_LOW              7
`define BIT_CALIBRATION_DONE        6
`define BIT_CHARGE_COUNT_OVER       5
`define BIT_REGULATION_SUMMARY      4
`define BIT_OVER_TEMPERATURE        3
`define BIT_BUS_FAULT               2
`define BIT_OTP_CRC_FAULT           1
`define BIT_OTP_LOADED              0

// Writable bits of the regulation flag and regulation unmask registers
`define REGULATION_BITS_MASK        8'h3f

`endif

// File: rtl/pmic_status_irq_flags.v
// Sticky status flags, unmask registers and interrupt pin of the power chip
//
// What this block does
// - Global bit 7 latches on supply low
// - Global bit 6 latches on calibration done
// - Global bit 5 latches on count over threshold
// - Global bit 4 latches on unmasked regulation flag
// - Global bit 3 latches on over temperature
// - Global bit 2 latches on bus fault
// - Global bit 1 latches on OTP CRC fault
// - Global bit 0 latches on each OTP load
// - Flags hold until host writes one
// - Global unmask gates flags, resets to 0x01
// - All other global flags masked at reset
// - Regulation bits 5:3 latch on leaving regulation
// - Regulation bits 2:0 latch on regaining regulation
// - Regulation unmask feeds summary, resets zero
// - Live bits 2:0 show present regulation state of enabled outputs
`timescale 1ns/100ps
`default_nettype none
`include "status_irq_defines.vh"

module pmic_status_irq_flags #(
	parameter ADDR_WIDTH = 5
) (
	input  wire                  core_clk,
	input  wire                  arst_n,
	// Avalon-MM slave
	input  wire [ADDR_WIDTH-1:0] address,
	input  wire                  read,
	input  wire                  write,
	input  wire [31:0]           writedata,
	input  wire [3:0]            byteenable,
	output wire [31:0]           readdata,
	output wire                  waitrequest,
	output wire [1:0]            response,
	// Event and condition inputs from other clock domains and analog
	input  wire                  supplyLowEvent,
	input  wire                  calibrationDoneEvent,
	input  wire                  chargeCountOverEvent,
	input  wire                  overTemperatureEvent,
	input  wire                  busFaultEvent,
	input  wire                  otpCrcFaultEvent,
	input  wire                  otpLoadedEvent,
	input  wire [2:0]            inRegulationNow,
	input  wire                  calibrationBusy,
	input  wire                  temperatureHighNow,
	input  wire                  supplyLowNow,
	// Converter enables from the OTP-loaded configuration
	input  wire [2:0]            outputEnabled,
	output wire                  irqOut,
	output wire [7:0]            conditionControl
);

	// ======================================================================
	// Input synchronisers
	localparam SYNC_WIDTH = 16;

	wire [SYNC_WIDTH-1:0] asyncIn;
	reg  [SYNC_WIDTH-1:0] syncA_reg;
	reg  [SYNC_WIDTH-1:0] syncB_reg;
	reg  [SYNC_WIDTH-1:0] syncC_reg;

	assign asyncIn = {outputEnabled, supplyLowNow, temperatureHighNow,
		calibrationBusy, inRegulationNow, otpLoadedEvent,
		otpCrcFaultEvent, busFaultEvent, overTemperatureEvent,
		chargeCountOverEvent, calibrationDoneEvent, supplyLowEvent};

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			syncA_reg <= {SYNC_WIDTH{1'b0}};
			syncB_reg <= {SYNC_WIDTH{1'b0}};
			syncC_reg <= {SYNC_WIDTH{1'b0}};
		end else begin
			syncA_reg <= asyncIn;
			syncB_reg <= syncA_reg;
			syncC_reg <= syncB_reg;
		end
	end

	wire [6:0] eventLevel;
	wire [6:0] eventPrev;
	wire [6:0] eventRise;
	wire [2:0] inRegSync;
	wire [2:0] inRegPrev;
	wire [2:0] enabledSync;

	assign eventLevel  = syncB_reg[6:0];
	assign eventPrev   = syncC_reg[6:0];
	assign eventRise   = eventLevel & ~eventPrev;
	assign inRegSync   = syncB_reg[9:7];
	assign inRegPrev   = syncC_reg[9:7];
	assign enabledSync = syncB_reg[15:13];

	// ======================================================================
	// Bus access
	localparam [1:0] RESP_OK     = 2'b00;
	localparam [1:0] RESP_DECERR = 2'b11;

	reg        readPending_reg;
	reg [31:0] readData_reg;
	reg [1:0]  response_reg;

	wire [ADDR_WIDTH-3:0] wordIndex;
	wire                  writeLow;

	assign wordIndex = address[ADDR_WIDTH-1:2];
	assign writeLow  = write & byteenable[0];

	function hit;
		input [ADDR_WIDTH-3:0] idx;
		input [2:0]            target;
		begin
			hit = ({3'b000, idx} == {{(ADDR_WIDTH-2){1'b0}}, target});
		end
	endfunction

	wire hitGlobalFlags;
	wire hitRegFlags;
	wire hitGlobalMask;
	wire hitRegMask;
	wire hitLive;
	wire hitControl;
	wire hitAny;

	assign hitGlobalFlags = hit(wordIndex, `GLOBAL_EVENT_FLAGS_IDX);
	assign hitRegFlags    = hit(wordIndex, `REGULATION_EVENT_FLAGS_IDX);
	assign hitGlobalMask  = hit(wordIndex, `GLOBAL_EVENT_UNMASK_IDX);
	assign hitRegMask     = hit(wordIndex, `REGULATION_EVENT_UNMASK_IDX);
	assign hitLive        = hit(wordIndex, `LIVE_CONDITION_VIEW_IDX);
	assign hitControl     = hit(wordIndex, `CONDITION_CONTROL_IDX);
	assign hitAny = hitGlobalFlags | hitRegFlags | hitGlobalMask |
		hitRegMask | hitLive | hitControl;

	// Writes complete at once; reads wait one cycle for registered data
	assign waitrequest = read & ~readPending_reg;
	assign readdata    = readData_reg;
	assign response    = response_reg;

	// ======================================================================
	// Flag and mask registers
	reg [7:0] globalFlags_reg;
	reg [7:0] globalFlags_next;
	reg [7:0] regFlags_reg;
	reg [7:0] regFlags_next;
	reg [7:0] globalMask_reg;
	reg [7:0] regMask_reg;
	reg [7:0] control_reg;
	reg       irq_reg;

	wire [7:0] globalClear;
	wire [7:0] regClear;
	wire [7:0] regSet;
	wire [7:0] globalSet;
	wire [7:0] liveView;

	assign globalClear = (writeLow & hitGlobalFlags) ?
		writedata[7:0] : 8'h00;
	assign regClear = (writeLow & hitRegFlags) ?
		(writedata[7:0] & `REGULATION_BITS_MASK) : 8'h00;

	assign regSet = {2'b00,
		~inRegSync & inRegPrev,
		inRegSync & ~inRegPrev};

	assign globalSet[`BIT_SUPPLY_LOW]         = eventRise[0];
	assign globalSet[`BIT_CALIBRATION_DONE]   = eventRise[1];
	assign globalSet[`BIT_CHARGE_COUNT_OVER]  = eventRise[2];
	assign globalSet[`BIT_REGULATION_SUMMARY] =
		|(regFlags_reg & regMask_reg);
	assign globalSet[`BIT_OVER_TEMPERATURE]   = eventRise[3];
	assign globalSet[`BIT_BUS_FAULT]          = eventRise[4];
	assign globalSet[`BIT_OTP_CRC_FAULT]      = eventRise[5];
	assign globalSet[`BIT_OTP_LOADED]         = eventRise[6];

	// Live bits 2:0 are qualified by converter enable; bits 5:3 are not
	assign liveView = {2'b00, syncB_reg[10], syncB_reg[11], syncB_reg[12],
		inRegSync & enabledSync};

	always @* begin
		globalFlags_next = (globalFlags_reg & ~globalClear) | globalSet;
		regFlags_next    = (regFlags_reg & ~regClear) | regSet;
	end

	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			globalFlags_reg <= `GLOBAL_FLAGS_RESET;
			regFlags_reg    <= `REGULATION_FLAGS_RESET;
			globalMask_reg  <= `GLOBAL_UNMASK_RESET;
			regMask_reg     <= `REGULATION_UNMASK_RESET;
			control_reg     <= `CONDITION_CONTROL_RESET;
			irq_reg         <= 1'b0;
		end else begin
			globalFlags_reg <= globalFlags_next;
			regFlags_reg    <= regFlags_next;
			if (writeLow & hitGlobalMask) begin
				globalMask_reg <= writedata[7:0];
			end
			if (writeLow & hitRegMask) begin
				regMask_reg <= writedata[7:0] & `REGULATION_BITS_MASK;
			end
			if (writeLow & hitControl) begin
				control_reg <= writedata[7:0];
			end
			irq_reg <= |(globalFlags_next & globalMask_reg);
		end
	end

	// ======================================================================
	// Read data path
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			readPending_reg <= 1'b0;
			readData_reg    <= 32'h00000000;
			response_reg    <= RESP_OK;
		end else begin
			readPending_reg <= read & ~readPending_reg;
			if (read & ~readPending_reg) begin
				response_reg <= hitAny ? RESP_OK : RESP_DECERR;
				if (hitGlobalFlags) begin
					readData_reg <= {24'h000000, globalFlags_reg};
				end else if (hitRegFlags) begin
					readData_reg <= {24'h000000, regFlags_reg};
				end else if (hitGlobalMask) begin
					readData_reg <= {24'h000000, globalMask_reg};
				end else if (hitRegMask) begin
					readData_reg <= {24'h000000, regMask_reg};
				end else if (hitLive) begin
					readData_reg <= {24'h000000, liveView};
				end else if (hitControl) begin
					readData_reg <= {24'h000000, control_reg};
				end else begin
					readData_reg <= 32'h00000000;
				end
			end else if (write) begin
				response_reg <= hitAny ? RESP_OK : RESP_DECERR;
			end
		end
	end

	assign irqOut           = irq_reg;
	assign conditionControl = control_reg;

endmodule

`default_nettype wire

// File: tb/event_source.sv
// Far-side event source that stretches fire strobes into level pulses
`timescale 1ns/100ps
`default_nettype none
module event_source (
	input  wire logic       core_clk,
	input  wire logic [7:0] fire,
	output var  logic [7:0] eventLevel = 8'h00
);
	logic [7:0] fireD1 = 8'h00;
	logic [7:0] fireD2 = 8'h00;
	always @(posedge core_clk) begin
		fireD1 <= fire;
		fireD2 <= fireD1;
		eventLevel <= fire | fireD1 | fireD2;
	end
endmodule
`default_nettype wire

// File: tb/status_irq_assertions.sv
// Port assertions for the status flag block
`timescale 1ns/100ps
`default_nettype none
module status_irq_assertions (
	input wire logic        core_clk,
	input wire logic        arst_n,
	input wire logic [4:0]  address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] writedata,
	input wire logic [3:0]  byteenable,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	input wire logic [1:0]  response,
	input wire logic        irqOut
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	wire logic rdDone = read && !waitrequest;
	write_no_wait_a: assert property (write |-> !waitrequest)
		else $error("write stalled");
	read_wait_once_a: assert property ($rose(read) |->
		waitrequest ##1 (!waitrequest || !read)) else $error("read wait");
	unmapped_resp_a: assert property (rdDone && address[4:2] > 3'h5 |->
		response == 2'b11 && readdata == 32'h0) else $error("unmapped");
	mapped_resp_a: assert property (rdDone && address[4:2] <= 3'h5 |->
		response == 2'b00 && readdata[31:8] == 24'h0) else $error("mapped");
	reserved_zero_a: assert property (rdDone &&
		(address[4:2] == 3'h1 || address[4:2] == 3'h3) |->
		readdata[7:6] == 2'b00) else $error("reserved bits");
	irq_reset_low_a: assert property ($rose(arst_n) |-> !irqOut[*2])
		else $error("irq after reset");
	mask_off_irq_a: assert property (write && !waitrequest &&
		byteenable[0] && address[4:2] == 3'h2 && writedata[7:0] == 8'h00
		|-> ##[1:3] !irqOut) else $error("masked irq");
	data_hold_a: assert property (!read && !write |=>
		$stable(readdata) && $stable(response)) else $error("data moved");
	cover property (rdDone && address[4:2] == 3'h0);
	cover property ($rose(irqOut));
	cover property (rdDone && response == 2'b11);
endmodule
bind pmic_status_irq_flags status_irq_assertions status_irq_assertions_inst (
	.core_clk(core_clk), .arst_n(arst_n), .address(address), .read(read),
	.write(write), .writedata(writedata), .byteenable(byteenable),
	.readdata(readdata), .waitrequest(waitrequest), .response(response),
	.irqOut(irqOut));
`default_nettype wire

// File: tb/pmic_status_irq_flags_bench.sv
// Self-checking bench for the status flag and interrupt block
`timescale 1ns/100ps
`default_nettype none
module pmic_status_irq_flags_bench;
	logic        core_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic [4:0]  address = 5'h00;
	logic        read = 1'b0;
	logic        write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [3:0]  byteenable = 4'hf;
	logic [2:0]  inReg = 3'h0;
	logic [7:0]  fire = 8'h00;
	logic [2:0]  outEn = 3'h7;
	logic [2:0]  liveMisc = 3'h0;
	logic [7:0]  ctrlOut;
	logic [7:0]  ev;
	logic [31:0] readdata;
	logic [1:0]  response;
	logic        waitrequest;
	logic        irqOut;
	logic [7:0]  got;
	int          bits[6] = '{7, 6, 5, 3, 2, 1};
	int          n_fail = 0;
	int          check_count = 0;
	initial forever #2 core_clk = ~core_clk;
	event_source event_source_inst (.core_clk(core_clk), .fire(fire),
		.eventLevel(ev));
	pmic_status_irq_flags pmic_status_irq_flags_inst (
		.core_clk(core_clk), .arst_n(arst_n), .address(address),
		.read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .response(response),
		.supplyLowEvent(ev[7]), .calibrationDoneEvent(ev[6]),
		.chargeCountOverEvent(ev[5]), .overTemperatureEvent(ev[3]),
		.busFaultEvent(ev[2]), .otpCrcFaultEvent(ev[1]),
		.otpLoadedEvent(ev[0]), .inRegulationNow(inReg),
		.calibrationBusy(liveMisc[2]), .temperatureHighNow(liveMisc[1]),
		.supplyLowNow(liveMisc[0]), .outputEnabled(outEn),
		.irqOut(irqOut), .conditionControl(ctrlOut));
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [2:0] idx, input logic [7:0] d);
		address <= {idx, 2'b00};
		writedata <= {24'h0, d};
		write <= 1'b1;
		@(posedge core_clk);
		while (waitrequest) @(posedge core_clk);
		write <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rc(input logic [2:0] idx, input logic [7:0] exp);
		address <= {idx, 2'b00};
		read <= 1'b1;
		@(posedge core_clk);
		while (waitrequest) @(posedge core_clk);
		got = readdata[7:0];
		read <= 1'b0;
		@(posedge core_clk);
		chk(got, exp);
	endtask
	task automatic chkIrq(input logic [7:0] exp);
		@(negedge core_clk);
		got = {7'h0, irqOut};
		@(posedge core_clk);
		chk(got, exp);
	endtask
	task automatic pulse(input logic [7:0] m);
		fire <= m;
		tick(1);
		fire <= 8'h00;
		tick(8);
	endtask
	task automatic close_out();
		$display("Checks %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		tick(4000);
		n_fail++;
		close_out();
	end
	initial begin
		tick(2);
		arst_n <= 1'b1;
		tick(1);
		rc(3'h2, 8'h01);
		rc(3'h3, 8'h00);
		rc(3'h1, 8'h00);
		pulse(8'h01);
		rc(3'h0, 8'h01);
		chkIrq(8'h01);
		wr(3'h0, 8'hfe);
		rc(3'h0, 8'h01);
		wr(3'h0, 8'h01);
		rc(3'h0, 8'h00);
		chkIrq(8'h00);
		foreach (bits[i]) begin
			pulse(8'h01 << bits[i]);
			rc(3'h0, 8'h01 << bits[i]);
			chkIrq(8'h00);
			wr(3'h0, 8'hff);
		end
		inReg <= 3'h7;
		tick(6);
		rc(3'h1, 8'h07);
		rc(3'h4, 8'h07);
		liveMisc <= 3'h5;
		outEn <= 3'h3;
		tick(4);
		rc(3'h4, 8'h2b);
		outEn <= 3'h7;
		liveMisc <= 3'h0;
		wr(3'h5, 8'ha5);
		rc(3'h5, 8'ha5);
		chk(ctrlOut, 8'ha5);
		rc(3'h0, 8'h00);
		wr(3'h1, 8'h3f);
		inReg <= 3'h0;
		tick(6);
		rc(3'h1, 8'h38);
		wr(3'h1, 8'h3f);
		wr(3'h3, 8'hff);
		rc(3'h3, 8'h3f);
		wr(3'h2, 8'h10);
		inReg <= 3'h2;
		tick(6);
		rc(3'h1, 8'h02);
		rc(3'h0, 8'h10);
		chkIrq(8'h01);
		wr(3'h2, 8'h00);
		chkIrq(8'h00);
		wr(3'h7, 8'hff);
		rc(3'h7, 8'h00);
		byteenable <= 4'h0;
		wr(3'h2, 8'hff);
		byteenable <= 4'hf;
		rc(3'h2, 8'h00);
		close_out();
	end
endmodule
`default_nettype wire
